// file: inc/ssu_defines.svh
// register offsets, field positions, reset values and timing counts of the serial data path
// assumes a 32-bit apb slave on a 20 mhz pclk
`ifndef SSU_DEFINES_SVH
`define SSU_DEFINES_SVH

// byte addresses of the word registers
`define OFS_CTRL        12'h000
`define OFS_MODE        12'h004
`define OFS_STAT        12'h008
`define OFS_TXD         12'h00C
`define OFS_RXD         12'h010
`define OFS_ICR         12'h014

// control word fields
`define CB_FLEN_LO      0
`define CB_FLEN_HI      1
`define CB_THREE_WIRE   2
`define CB_SINGLE_WIRE  3
`define CB_MASTER       4
`define CB_CLK_PIN      5
`define CB_TX_EN        6
`define CB_RX_EN        7
`define CTRL_W          8
`define CTRL_RST        8'h00

// mode word fields
`define MB_RATE_LO      0
`define MB_RATE_HI      2
`define MB_PHASE        3
`define MB_POL          4
`define MB_MSB_FIRST    5
`define MODE_W          6
`define MODE_RST        6'h00

// status word fields
`define SB_TX_EMPTY     0
`define SB_RX_FULL      1
`define SB_OVERRUN      2

// frame length codes
`define FLEN_8          2'h0
`define FLEN_16         2'h1
`define FLEN_32         2'h2
`define FLEN_BAD        2'h3

// input buffer control: one enable per pin
`define ICR_W           3
`define IB_SI           0
`define IB_SO           1
`define IB_SCK          2

// shift clock rate: half period = 2**rate pclk cycles
`define RATE_W          3
`define DIV_W           8
`define BITS_PER_BYTE   4'h8
`define BYTE_IDX_W      2

`endif

// file: inc/ssu_pkg.sv
// types shared by the serial data path modules
// assumes ssu_defines.svh for field widths
`include "ssu_defines.svh"
package ssu_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b10
    } xfer_state_t;

    typedef enum logic [1:0] {
        PIN_UNUSED = 2'b00,
        PIN_IN     = 2'b01,
        PIN_OUT    = 2'b10
    } pin_role_t;
endpackage

// file: rtl/pin_sync.sv
// two-flop synchroniser for pins and the external shift clock
// assumes the input is asynchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // first flop feeds only the second
    always_comb begin
        s_d      = s_q;
        s_d.meta = din;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.sync;
endmodule // pin_sync
`default_nettype wire

// file: rtl/clk_divider.sv
// shift clock generator for master mode: eight rates from pclk
// assumes rate is held steady while running
`timescale 1ns/1ns
`default_nettype none
`include "ssu_defines.svh"
module clk_divider
    import ssu_pkg::*;
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // control
    input  wire logic                run,
    input  wire logic [`RATE_W-1:0]  rate,
    // output: one-cycle pulse at each half period
    output logic                     tick
);
    typedef struct packed {
        logic [`DIV_W-1:0] cnt;
        logic              tick;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    // half period of 2**rate cycles; restarts whenever idle
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= ((`DIV_W'(1) << rate) - `DIV_W'(1))) begin
            s_d.cnt  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + `DIV_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule // clk_divider
`default_nettype wire

// file: rtl/sync_serial_datapath.sv
// data path and pin routing of the synchronous serial unit, with an apb register slave
// assumes pins arrive asynchronous to pclk and the pad ring resolves the output enables
// How it works
// - frame length selects valid receive byte lanes
// - full byte goes to its lane; the last byte of a frame moves the frame to receive data
// - receive lanes read-only, eight bits, reset zero
// - msb first select picks transmit bit order
// - transmit shifts out from shift bit 0
// - receive shifts in at bit 7, then transfers
// - no software path into shift register
// - master drives shift clock at selected rate
// - slave takes shift clock from pin
// - three-wire mode ignores phase, honours polarity
// - standard master: out pin sends, in pin receives
// - standard slave: in pin sends, out pin receives
// - single-wire: out pin sends and receives alone
// - single-wire never transmits and receives together
// - three-wire: out sends, in receives always
// - three-wire master drives clock, slave inputs
// - clock pin released when clock select zero
// - reading receive data clears full flag
// - empty shift register loads pending transmit data
// - full at eighth edge sets overrun, stops
`timescale 1ns/1ns
`default_nettype none
`include "ssu_defines.svh"
module sync_serial_datapath
    import ssu_pkg::*;
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // shift clock pin
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    // serial out pin
    input  wire logic        so_in,
    output logic             so_out,
    output logic             so_oe,
    // serial in pin
    input  wire logic        si_in,
    output logic             si_out,
    output logic             si_oe
);
    import ssu_pkg::*;

    typedef struct packed {
        logic [`CTRL_W-1:0]     ctrl;
        logic [`MODE_W-1:0]     mode;
        logic [`ICR_W-1:0]      input_buffer_control;
        logic [31:0]            txd;
        logic                   tx_pend;
        logic [31:0]            rxd;
        logic                   rx_full;
        logic                   overrun;
        xfer_state_t            st;
        logic [7:0]             shift;
        logic [3:0]             bitn;
        logic [`BYTE_IDX_W-1:0] byte_idx;
        logic [31:0]            acc;
        logic [31:0]            tx_word;
        logic                   sck_lvl;
        logic                   sck_prev;
        logic                   dout;
        logic [31:0]            rdata;
    } core_state_t;

    core_state_t s_q;
    core_state_t s_d;

    logic sck_s;
    logic so_s;
    logic si_s;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // number of bytes in a frame minus one
    function automatic logic [`BYTE_IDX_W-1:0] last_byte(input logic [1:0] flen);
        case (flen)
            `FLEN_8:  last_byte = 2'h0;
            `FLEN_16: last_byte = 2'h1;
            `FLEN_32: last_byte = 2'h3;
            default:  last_byte = 2'h0;
        endcase
    endfunction

    // bit-reverse a byte
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = b[7-i];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin inputs through two flops each

    pin_sync u_sync_sck (.pclk(pclk), .presetn(presetn), .din(sck_in), .dout(sck_s));
    pin_sync u_sync_so  (.pclk(pclk), .presetn(presetn), .din(so_in),  .dout(so_s));
    pin_sync u_sync_si  (.pclk(pclk), .presetn(presetn), .din(si_in),  .dout(si_s));

    clk_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (s_q.st == ST_SHIFT),
        .rate    (s_q.mode[`MB_RATE_HI:`MB_RATE_LO]),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mode decode

    logic       master, three_w, single_w, tx_en, rx_en, clk_sel, pol, pha, msb;
    logic [1:0] flen;
    logic       rx_bit, lead_edge, trail_edge, sample_edge, drive_edge;
    logic       do_tx, do_rx;
    logic       apb_wr, apb_rd;

    always_comb begin
        master   = s_q.ctrl[`CB_MASTER];
        three_w  = s_q.ctrl[`CB_THREE_WIRE];
        single_w = s_q.ctrl[`CB_SINGLE_WIRE] & ~three_w;
        tx_en    = s_q.ctrl[`CB_TX_EN];
        rx_en    = s_q.ctrl[`CB_RX_EN];
        clk_sel  = s_q.ctrl[`CB_CLK_PIN];
        flen     = s_q.ctrl[`CB_FLEN_HI:`CB_FLEN_LO];
        pol      = s_q.mode[`MB_POL];
        pha      = s_q.mode[`MB_PHASE] & ~three_w;
        msb      = s_q.mode[`MB_MSB_FIRST];
        // single wire: transmit wins, never both
        do_tx    = tx_en;
        do_rx    = rx_en & ~(single_w & tx_en) & ~s_q.overrun;
        // receive pin per mode
        if (three_w) begin
            rx_bit = si_s;
        end else if (single_w) begin
            rx_bit = so_s;
        end else if (master) begin
            rx_bit = si_s;
        end else begin
            rx_bit = so_s;
        end
        // edges of the shift clock, own or external, polarity removed
        if (master) begin
            lead_edge  = tick & (s_q.sck_lvl == pol);
            trail_edge = tick & (s_q.sck_lvl != pol);
        end else begin
            lead_edge  = clk_sel & ((sck_s ^ pol) & ~(s_q.sck_prev ^ pol));
            trail_edge = clk_sel & (~(sck_s ^ pol) & (s_q.sck_prev ^ pol));
        end
        sample_edge = pha ? trail_edge : lead_edge;
        drive_edge  = pha ? lead_edge : trail_edge;
        apb_wr      = psel & penable & pwrite;
        apb_rd      = psel & penable & ~pwrite;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d          = s_q;
        s_d.sck_prev = sck_s;

        // register writes; shift register has no address
        if (apb_wr) begin
            case (paddr)
                `OFS_CTRL: s_d.ctrl = pwdata[`CTRL_W-1:0];
                `OFS_MODE: s_d.mode = pwdata[`MODE_W-1:0];
                `OFS_ICR:  s_d.input_buffer_control  = pwdata[`ICR_W-1:0];
                `OFS_TXD: begin
                    s_d.txd     = pwdata;
                    s_d.tx_pend = 1'b1;
                end
                `OFS_STAT: begin
                    if (!pwdata[`SB_OVERRUN]) begin
                        s_d.overrun = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // reading receive data clears the full flag
        if (apb_rd && paddr == `OFS_RXD) begin
            s_d.rx_full = 1'b0;
        end

        // transfer sequencer
        case (s_q.st)
            ST_IDLE: begin
                s_d.sck_lvl = pol;
                if ((do_tx && s_q.tx_pend) || (do_rx && !do_tx && master && apb_rd && paddr == `OFS_RXD)
                    || (do_rx && !master)) begin
                    s_d.tx_word  = s_q.txd;
                    s_d.tx_pend  = do_tx ? 1'b0 : s_q.tx_pend;
                    s_d.shift    = msb ? rev8(s_q.txd[7:0]) : s_q.txd[7:0];
                    s_d.dout     = msb ? s_q.txd[7] : s_q.txd[0];
                    s_d.bitn     = '0;
                    s_d.byte_idx = '0;
                    s_d.st       = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (tick && master) begin
                    s_d.sck_lvl = ~s_q.sck_lvl;
                end
                if (sample_edge) begin
                    // eighth edge with data still unread
                    if (s_q.bitn == `BITS_PER_BYTE - 4'h1 && s_q.rx_full && do_rx) begin
                        s_d.overrun = 1'b1;
                    end
                    s_d.shift = {s_q.shift[0] ? s_q.shift[7:1] : s_q.shift[7:1], 1'b0};
                    s_d.shift = {rx_bit, s_q.shift[7:1]};
                    s_d.bitn  = s_q.bitn + 4'h1;
                end
                if (drive_edge && s_q.bitn != '0) begin
                    s_d.dout = s_q.shift[0];
                end
                if (s_q.bitn == `BITS_PER_BYTE && (!master || s_q.sck_lvl == pol)) begin
                    s_d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                // bits arrived at bit 7 side and moved down; undo order for msb first
                s_d.acc[8*s_q.byte_idx +: 8] = msb ? rev8(s_q.shift) : s_q.shift;
                if (s_q.byte_idx == last_byte(flen)) begin
                    if (do_rx && !s_q.overrun) begin
                        s_d.rxd      = s_q.acc;
                        s_d.rxd[8*s_q.byte_idx +: 8] = msb ? rev8(s_q.shift) : s_q.shift;
                        s_d.rx_full  = 1'b1;
                    end
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.byte_idx = s_q.byte_idx + 2'h1;
                    s_d.shift    = msb ? rev8(s_q.tx_word[8*(s_q.byte_idx+2'h1) +: 8])
                                       : s_q.tx_word[8*(s_q.byte_idx+2'h1) +: 8];
                    // first bit of the next byte must stand before its first sample edge
                    s_d.dout     = s_d.shift[0];
                    s_d.bitn     = '0;
                    s_d.st       = ST_SHIFT;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // read data, lanes beyond frame length read zero
        s_d.rdata = '0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFS_CTRL: s_d.rdata = 32'(s_q.ctrl);
                `OFS_MODE: s_d.rdata = 32'(s_q.mode);
                `OFS_ICR:  s_d.rdata = 32'(s_q.input_buffer_control);
                `OFS_TXD:  s_d.rdata = s_q.txd;
                `OFS_STAT: s_d.rdata = {29'h0, s_q.overrun, s_q.rx_full, ~s_q.tx_pend};
                `OFS_RXD: begin
                    case (flen)
                        `FLEN_8:  s_d.rdata = {24'h0, s_q.rxd[7:0]};
                        `FLEN_16: s_d.rdata = {16'h0, s_q.rxd[15:0]};
                        `FLEN_32: s_d.rdata = s_q.rxd;
                        default:  s_d.rdata = '0;
                    endcase
                end
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q      <= '0;
            s_q.ctrl <= `CTRL_RST;
            s_q.mode <= `MODE_RST;
            s_q.st   <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answers: read data captured in setup, zero wait states

    assign prdata  = s_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // pin routing; input buffer control register is only stored and gates no input

    logic active_tx;
    assign active_tx = do_tx && (s_q.st != ST_IDLE);

    // shift clock pin: released when not selected
    assign sck_oe  = clk_sel & master;
    assign sck_out = s_q.sck_lvl;

    // serial out pin drives in master, three-wire and single-wire transmit
    assign so_oe  = active_tx & (three_w | single_w | master);
    assign so_out = s_q.dout;

    // serial in pin drives only in standard slave transmit
    assign si_oe  = active_tx & ~three_w & ~single_w & ~master;
    assign si_out = s_q.dout;
endmodule // sync_serial_datapath
`default_nettype wire

// file: testbench/ssu_chk.sv
// assertions on the apb side and pin enables of the serial data path
// assumes binding to sync_serial_datapath; sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "ssu_defines.svh"
module ssu_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // pin enables
    input wire logic        sck_oe,
    input wire logic        so_oe,
    input wire logic        si_oe
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic       ss_mode;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // shadow of the control word, follows completed writes
    always_comb begin
        ctrl_d = ctrl_q;
        if (psel && penable && pwrite && paddr == `OFS_CTRL) begin
            ctrl_d = pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    assign ss_mode = !ctrl_q[`CB_THREE_WIRE] && !ctrl_q[`CB_SINGLE_WIRE] && !ctrl_q[`CB_MASTER];
    ////////////////////////////////////////////////////////////////
    // settled: registered enables may trail a mode write by one cycle
    sequence s_settled;
        $stable(ctrl_q);
    endsequence
    sequence s_rx_read;
        psel && penable && !pwrite && paddr == `OFS_RXD;
    endsequence
    property p_sck_slave;
        s_settled ##0 !ctrl_q[`CB_MASTER] |-> !sck_oe;
    endproperty
    a_sck_slave: assert property (p_sck_slave) else $error("clock pin driven in slave mode");
    property p_sck_free;
        s_settled ##0 !ctrl_q[`CB_CLK_PIN] |-> !sck_oe;
    endproperty
    a_sck_free: assert property (p_sck_free) else $error("clock pin driven while released");
    property p_sck_master;
        s_settled ##0 (ctrl_q[`CB_MASTER] && ctrl_q[`CB_CLK_PIN]) |-> sck_oe;
    endproperty
    a_sck_master: assert property (p_sck_master) else $error("master not driving clock pin");
    property p_si_dir;
        s_settled ##0 !ss_mode |-> !si_oe;
    endproperty
    a_si_dir: assert property (p_si_dir) else $error("in pin driven outside standard slave");
    property p_so_dir;
        s_settled ##0 ss_mode |-> !so_oe;
    endproperty
    a_so_dir: assert property (p_so_dir) else $error("out pin driven in standard slave");
    property p_single_rx;
        s_settled ##0 (ctrl_q[`CB_SINGLE_WIRE] && !ctrl_q[`CB_TX_EN]) |-> !so_oe && !si_oe;
    endproperty
    a_single_rx: assert property (p_single_rx) else $error("single wire receive drives a pin");
    property p_lane8;
        s_rx_read ##0 ctrl_q[1:0] == `FLEN_8 |-> prdata[31:8] == 24'h000000;
    endproperty
    a_lane8: assert property (p_lane8) else $error("upper lanes nonzero in 8-bit frame");
    property p_unmapped;
        psel && penable && !pwrite && paddr > `OFS_ICR |-> prdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // ssu_chk
bind sync_serial_datapath ssu_chk ssu_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .sck_oe, .so_oe, .si_oe);
`default_nettype wire

// file: testbench/serial_peer.sv
// far-side serial peer: clock source in slave tests, shifts a byte each way
// assumes the bench resolves pins; clock idles high, sampling on rising edge
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    // resolved pins
    input  wire logic       sck_pin,
    input  wire logic       so_pin,
    input  wire logic       si_pin,
    // levels driven by the peer
    output logic            sck_drv,
    output logic            so_drv,
    output logic            si_drv,
    // command and capture
    input  wire logic       go,
    input  wire logic       use_si,
    input  wire logic       make_clk,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_so,
    output logic [7:0]      rx_si
);
    int   cnt = 8;
    logic bit_v = 1'b0;
    // all lines idle high until the first frame is armed
    initial {sck_drv, so_drv, si_drv} = 3'b111;
    // unused data pin carries the inverse so a wrong pin choice shows
    task automatic drive();
        so_drv = use_si ? ~bit_v : bit_v;
        si_drv = use_si ? bit_v : ~bit_v;
    endtask
    ////////////////////////////////////////////////////////////////
    // arm a frame; clock only when the peer is the master
    always @(posedge go) begin
        cnt = 0;
        bit_v = tx_byte[0];
        drive();
        if (make_clk) begin
            #73;
            repeat (8) begin
                sck_drv = 1'b0;
                #200;
                sck_drv = 1'b1;
                #200;
            end
        end
    end
    // next bit on falling clock, indexed by rising edges seen, so a clock
    // that idles low does not repeat bit 0; after the frame lines toggle
    always @(negedge sck_pin) begin
        if (cnt < 8) begin
            bit_v = tx_byte[cnt];
        end else begin
            bit_v = ~bit_v;
        end
        drive();
    end
    // capture on rising clock, first bit lands in bit 0
    always @(posedge sck_pin) begin
        rx_so = {so_pin, rx_so[7:1]};
        rx_si = {si_pin, rx_si[7:1]};
        if (cnt < 8) begin
            cnt++;
        end
    end
endmodule // serial_peer
`default_nettype wire

// file: testbench/sync_serial_datapath_tb.sv
// self-checking bench of the serial data path over apb
// assumes serial_peer as far side; the bench resolves the pin levels
`timescale 1ns/1ns
`default_nettype none
`include "ssu_defines.svh"
module sync_serial_datapath_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sck_in, sck_out, sck_oe, so_in, so_out, so_oe, si_in, si_out, si_oe;
    logic        sck_drv, so_drv, si_drv, go, use_si, make_clk;
    logic [7:0]  tx_byte, rx_so, rx_si;
    logic [7:0]  cv [3] = '{8'hA0, 8'hA8, 8'hA4};
    logic [7:0]  pat [3] = '{8'h5B, 8'hC3, 8'h96};
    int          fail_count = 0;
    int          num_checks = 0;
    // pin levels from the data path's enables, peer drives otherwise
    assign sck_in = sck_oe ? sck_out : sck_drv;
    assign so_in  = so_oe ? so_out : so_drv;
    assign si_in  = si_oe ? si_out : si_drv;
    sync_serial_datapath sync_serial_datapath_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sck_in, .sck_out, .sck_oe, .so_in, .so_out, .so_oe,
        .si_in, .si_out, .si_oe);
    serial_peer serial_peer_inst (.sck_pin(sck_in), .so_pin(so_in), .si_pin(si_in), .sck_drv, .so_drv,
        .si_drv, .go, .use_si, .make_clk, .tx_byte, .rx_so, .rx_si);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no bound here; the watchdog ends this wait if pready stays low
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // bounded poll of one status bit
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, `OFS_STAT, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 300);
        chk("status bit", 32'h1, {31'h0, rd[b]});
    endtask
    task automatic frame(input logic [7:0] b, input logic s, input logic mk);
        tx_byte <= b;
        use_si <= s;
        make_clk <= mk;
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs roughly a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, go, use_si, make_clk} = 7'h00;
        {paddr, pwdata, tx_byte} = 52'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `OFS_RXD, 32'h0);
        chk("rx reset", 32'h0, rd);
        chk("apb answer", 32'h2, {30'h0, pready, pslverr});
        apb(1'b1, `OFS_RXD, 32'hFFFFFFFF);
        apb(1'b0, `OFS_RXD, 32'h0);
        chk("rx write ignored", 32'h0, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test access done");
        // master transfer in both bit orders, peer answers on in pin
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `OFS_CTRL, 32'h0);
            apb(1'b1, `OFS_ICR, 32'h1);
            apb(1'b1, `OFS_MODE, 32'h3 | (m << 5));
            apb(1'b1, `OFS_CTRL, 32'hF0);
            frame(8'hA6, 1'b1, 1'b0);
            apb(1'b1, `OFS_TXD, 32'h1D);
            wait_bit(`SB_RX_FULL);
            chk("tx bits", {24'h0, m ? 8'hB8 : 8'h1D}, {24'h0, rx_so});
            apb(1'b0, `OFS_RXD, 32'h0);
            chk("master rx", {24'h0, m ? 8'h65 : 8'hA6}, rd);
            apb(1'b0, `OFS_STAT, 32'h0);
            chk("full cleared", 32'h0, {31'h0, rd[`SB_RX_FULL]});
        end
        $display("test master done");
        // slave receive: standard, single wire, three wire with phase set
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `OFS_CTRL, 32'h0);
            apb(1'b1, `OFS_ICR, 32'h7);
            apb(1'b1, `OFS_MODE, k == 2 ? 32'h08 : 32'h00);
            apb(1'b1, `OFS_CTRL, {24'h0, cv[k]});
            frame(pat[k], k == 2, 1'b1);
            wait_bit(`SB_RX_FULL);
            apb(1'b0, `OFS_RXD, 32'h0);
            chk("slave rx", {24'h0, pat[k]}, rd);
        end
        $display("test slave done");
        // second frame while the first is unread
        apb(1'b1, `OFS_CTRL, 32'h0);
        apb(1'b1, `OFS_MODE, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'hA0);
        frame(8'h11, 1'b0, 1'b1);
        wait_bit(`SB_RX_FULL);
        frame(8'h22, 1'b0, 1'b1);
        wait_bit(`SB_OVERRUN);
        chk("overrun set", 32'h1, {31'h0, rd[`SB_OVERRUN]});
        apb(1'b0, `OFS_RXD, 32'h0);
        chk("first byte kept", 32'h11, rd);
        apb(1'b1, `OFS_STAT, 32'h0);
        apb(1'b0, `OFS_STAT, 32'h0);
        chk("overrun cleared", 32'h0, {31'h0, rd[`SB_OVERRUN]});
        $display("test overrun done");
        // two-byte slave frame fills lanes 0 and 1
        apb(1'b1, `OFS_CTRL, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'hA1);
        frame(8'h3C, 1'b0, 1'b1);
        repeat (80) @(posedge pclk);
        frame(8'h5A, 1'b0, 1'b1);
        wait_bit(`SB_RX_FULL);
        apb(1'b0, `OFS_RXD, 32'h0);
        chk("two lanes", 32'h00005A3C, rd);
        $display("test lanes done");
        report_and_stop();
    end
endmodule // sync_serial_datapath_tb
`default_nettype wire
